// ### design/clock_gating_pkg.sv
// constants for the peripheral clock gating block
package clock_gating_pkg;

    // register word offsets (byte addresses)
    localparam logic [7:0] GATE_A_OFFSET = 8'h00;
    localparam logic [7:0] GATE_B_OFFSET = 8'h04;
    localparam logic [7:0] GATE_C_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0c;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // group a field positions
    localparam int TWO_WIRE_PORT_GATE_BIT = 6;

    // group b field positions
    localparam int LOWPOWER_SERIAL_GATE_BIT = 20;
    localparam int SECOND_GPIO_GATE_BIT = 10;
    localparam int FIRST_GPIO_GATE_BIT = 9;
    localparam int LOWPOWER_TIMER_ACCESS_BIT = 0;

    // group c field positions
    localparam int RTC_ACCESS_BIT = 29;
    localparam int CONVERTER_GATE_BIT = 27;
    localparam int PWM_TIMER_ONE_GATE_BIT = 25;
    localparam int PWM_TIMER_ZERO_GATE_BIT = 24;
    localparam int FLASH_GATE_BIT = 0;

    // status field positions
    localparam int STAT_FLASH_GATED_BIT = 0;
    localparam int STAT_LP_BLOCKED_BIT = 1;
    localparam int STAT_FLASH_READ_BIT = 2;
    localparam int STAT_LP_GRANTED_BIT = 3;

    // writable masks per group
    localparam logic [31:0] GATE_A_WMASK = 32'h0000_0040;
    localparam logic [31:0] GATE_B_WMASK = 32'h0010_0601;
    localparam logic [31:0] GATE_C_WMASK = 32'h2b00_0001;

    // reserved bits that read as one
    localparam logic [31:0] GATE_A_ONES = 32'h0000_0030;
    localparam logic [31:0] GATE_B_ONES = 32'h0000_0182;
    localparam logic [31:0] GATE_C_ONES = 32'h0000_0000;

    // reset values of the writable bits
    localparam logic [31:0] GATE_A_RESET = 32'h0000_0000;
    localparam logic [31:0] GATE_B_RESET = 32'h0000_0000;
    localparam logic [31:0] GATE_C_RESET = 32'h0000_0001;

    // number of gated clock outputs
    localparam int NUM_GATES = 8;

    // index of each gated clock in the enable vector
    localparam int GI_TWO_WIRE = 0;
    localparam int GI_LP_SERIAL = 1;
    localparam int GI_GPIO_TWO = 2;
    localparam int GI_GPIO_ONE = 3;
    localparam int GI_CONVERTER = 4;
    localparam int GI_PWM_ONE = 5;
    localparam int GI_PWM_ZERO = 6;
    localparam int GI_FLASH = 7;

    // low-power entry arbitration states
    typedef enum logic [1:0] {
        LP_IDLE,
        LP_GRANT,
        LP_BLOCK
    } lp_state_t;

endpackage

// ### design/glitch_free_gate.sv
// latch-based glitch-free clock gate cell
`timescale 1ns/1ps
module glitch_free_gate (
    // clock and enable
    input wire logic clk_i,
    input wire logic en_i,
    // gated clock
    output logic gclk_o
);

    logic en_latched;

    // enable only moves while the clock is low, so no runt pulse
    always_latch begin
        if (!clk_i) begin
            en_latched = en_i;
        end
    end

    assign gclk_o = clk_i & en_latched;

endmodule

// ### design/peripheral_clock_gating.sv
// peripheral clock gating registers with gated clocks and access enables
//
// What this block does
// RULE_01: bit 6 of group a gates the two-wire port clock, 0 off and 1 on.
// RULE_02: bit 20 of group b gates the low-power serial clock, 0 off, 1 on.
// RULE_03: bit 10 of group b gates the second gpio port clock, 0 off, 1 on.
// RULE_04: bit 9 of group b gates the first gpio port clock, 0 off, 1 on.
// RULE_05: bit 0 of group b allows software access to the low-power timer.
// RULE_06: bit 29 of group c enables real-time clock access and interrupts.
// RULE_07: bit 27 of group c gates the converter clock, 0 off, 1 on.
// RULE_08: bit 25 of group c gates the second pwm timer clock, 0 off, 1 on.
// RULE_09: bit 24 of group c gates the first pwm timer clock, 0 off, 1 on.
// RULE_10: bit 0 of group c gates the flash clock, 0 off and 1 on.
// RULE_11: flash reads keep working while the flash gate bit is clear.
// RULE_12: low-power mode entry is refused while the flash gate bit is clear.
// RULE_13: reserved bits 5-4 of group a and 8-7 and 1 of group b read one.
// RULE_14: all other reserved bits of the three groups read zero.
// RULE_15: writes to reserved bits are ignored and gated clocks never glitch.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module peripheral_clock_gating (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [clock_gating_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [clock_gating_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [clock_gating_pkg::DATA_W-1:0] reg_rdata_o,
    // gated peripheral clocks
    output logic two_wire_port_gclk_o,
    output logic lowpower_serial_gclk_o,
    output logic second_gpio_gclk_o,
    output logic first_gpio_gclk_o,
    output logic converter_gclk_o,
    output logic pwm_timer_one_gclk_o,
    output logic pwm_timer_zero_gclk_o,
    output logic flash_gclk_o,
    // gate levels for synchronous consumers
    output logic two_wire_port_gate_o,
    output logic lowpower_serial_gate_o,
    output logic second_gpio_gate_o,
    output logic first_gpio_gate_o,
    output logic converter_gate_o,
    output logic pwm_timer_one_gate_o,
    output logic pwm_timer_zero_gate_o,
    output logic flash_gate_o,
    // low-power timer access
    output logic lowpower_timer_access_o,
    input wire logic timer_sel_i,
    output logic timer_sel_o,
    // real-time clock access and interrupt
    output logic rtc_access_o,
    input wire logic rtc_sel_i,
    output logic rtc_sel_o,
    input wire logic rtc_irq_i,
    output logic rtc_irq_o,
    // flash read path
    input wire logic flash_read_i,
    output logic flash_read_clk_en_o,
    // low-power mode entry
    input wire logic lp_entry_req_i,
    output logic lp_entry_grant_o,
    output logic lp_entry_refused_o
);

    import clock_gating_pkg::*;

    // merge a write into a group, touching only writable bits
    function automatic logic [31:0] merge_write(
        input logic [31:0] wdata,
        input logic [31:0] wmask
    );
        merge_write = wdata & wmask;
    endfunction

    // software view of a group: stored bits plus fixed ones
    function automatic logic [31:0] group_view(
        input logic [31:0] stored,
        input logic [31:0] wmask,
        input logic [31:0] ones
    );
        group_view = (stored & wmask) | ones;
    endfunction

    // register state
    logic [31:0] gate_a_q;
    logic [31:0] gate_a_d;
    logic [31:0] gate_b_q;
    logic [31:0] gate_b_d;
    logic [31:0] gate_c_q;
    logic [31:0] gate_c_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // address decode
    wire sel_a = (reg_addr_i == GATE_A_OFFSET);
    wire sel_b = (reg_addr_i == GATE_B_OFFSET);
    wire sel_c = (reg_addr_i == GATE_C_OFFSET);
    wire sel_stat = (reg_addr_i == STATUS_OFFSET);
    wire wr_a = reg_write_i & sel_a;
    wire wr_b = reg_write_i & sel_b;
    wire wr_c = reg_write_i & sel_c;

    // reserved bits never stored, so writes to them vanish
    assign gate_a_d = wr_a ? merge_write(reg_wdata_i, GATE_A_WMASK)
                           : gate_a_q; // see RULE_15
    assign gate_b_d = wr_b ? merge_write(reg_wdata_i, GATE_B_WMASK)
                           : gate_b_q; // see RULE_15
    assign gate_c_d = wr_c ? merge_write(reg_wdata_i, GATE_C_WMASK)
                           : gate_c_q; // see RULE_15

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gate_a_q <= GATE_A_RESET;
            gate_b_q <= GATE_B_RESET;
            gate_c_q <= GATE_C_RESET;
        end else begin
            gate_a_q <= gate_a_d;
            gate_b_q <= gate_b_d;
            gate_c_q <= gate_c_d;
        end
    end

    // field extraction
    wire two_wire_en = gate_a_q[TWO_WIRE_PORT_GATE_BIT]; // see RULE_01
    wire lp_serial_en = gate_b_q[LOWPOWER_SERIAL_GATE_BIT]; // see RULE_02
    wire gpio_two_en = gate_b_q[SECOND_GPIO_GATE_BIT]; // see RULE_03
    wire gpio_one_en = gate_b_q[FIRST_GPIO_GATE_BIT]; // see RULE_04
    wire timer_acc_en = gate_b_q[LOWPOWER_TIMER_ACCESS_BIT]; // see RULE_05
    wire rtc_acc_en = gate_c_q[RTC_ACCESS_BIT]; // see RULE_06
    wire converter_en = gate_c_q[CONVERTER_GATE_BIT]; // see RULE_07
    wire pwm_one_en = gate_c_q[PWM_TIMER_ONE_GATE_BIT]; // see RULE_08
    wire pwm_zero_en = gate_c_q[PWM_TIMER_ZERO_GATE_BIT]; // see RULE_09
    wire flash_en = gate_c_q[FLASH_GATE_BIT]; // see RULE_10

    // flash keeps a clock for reads even when gated off
    wire flash_clk_need = flash_en | flash_read_i; // see RULE_11

    // gate enable vector
    logic [NUM_GATES-1:0] gate_en;
    logic [NUM_GATES-1:0] gclk;

    assign gate_en[GI_TWO_WIRE] = two_wire_en;
    assign gate_en[GI_LP_SERIAL] = lp_serial_en;
    assign gate_en[GI_GPIO_TWO] = gpio_two_en;
    assign gate_en[GI_GPIO_ONE] = gpio_one_en;
    assign gate_en[GI_CONVERTER] = converter_en;
    assign gate_en[GI_PWM_ONE] = pwm_one_en;
    assign gate_en[GI_PWM_ZERO] = pwm_zero_en;
    assign gate_en[GI_FLASH] = flash_clk_need;

    // one latch cell per consumer; register enables change only on a rising edge, the flash one also follows flash_read_i
    // so the latch sees a stable value through the low phase
    for (genvar g = 0; g < NUM_GATES; g++) begin : gen_gate
        glitch_free_gate u_gate (
            .clk_i (core_clk_i),
            .en_i (gate_en[g]),
            .gclk_o (gclk[g])
        ); // see RULE_15
    end

    assign two_wire_port_gclk_o = gclk[GI_TWO_WIRE];
    assign lowpower_serial_gclk_o = gclk[GI_LP_SERIAL];
    assign second_gpio_gclk_o = gclk[GI_GPIO_TWO];
    assign first_gpio_gclk_o = gclk[GI_GPIO_ONE];
    assign converter_gclk_o = gclk[GI_CONVERTER];
    assign pwm_timer_one_gclk_o = gclk[GI_PWM_ONE];
    assign pwm_timer_zero_gclk_o = gclk[GI_PWM_ZERO];
    assign flash_gclk_o = gclk[GI_FLASH];

    // gate levels straight from the register flops
    assign two_wire_port_gate_o = two_wire_en;
    assign lowpower_serial_gate_o = lp_serial_en;
    assign second_gpio_gate_o = gpio_two_en;
    assign first_gpio_gate_o = gpio_one_en;
    assign converter_gate_o = converter_en;
    assign pwm_timer_one_gate_o = pwm_one_en;
    assign pwm_timer_zero_gate_o = pwm_zero_en;
    assign flash_gate_o = flash_en;
    assign flash_read_clk_en_o = flash_clk_need;

    // access enables: selects are blocked, not delayed
    assign lowpower_timer_access_o = timer_acc_en;
    assign timer_sel_o = timer_sel_i & timer_acc_en; // see RULE_05
    assign rtc_access_o = rtc_acc_en;
    assign rtc_sel_o = rtc_sel_i & rtc_acc_en; // see RULE_06

    // rtc interrupt is masked by the same bit, registered for a clean level
    logic rtc_irq_q;
    wire rtc_irq_d = rtc_irq_i & rtc_acc_en; // see RULE_06

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rtc_irq_q <= 1'b0;
        end else begin
            rtc_irq_q <= rtc_irq_d;
        end
    end

    assign rtc_irq_o = rtc_irq_q;

    // low-power entry arbitration
    // a refusal is held while the request stays high, a grant only while flash stays ungated; a request raised
    // while flash is gated stays refused even if software ungates later,
    // until the requester drops and asks again
    lp_state_t lp_state_q;
    lp_state_t lp_state_d;

    always_comb begin
        lp_state_d = lp_state_q;
        case (lp_state_q)
            LP_IDLE: begin
                if (lp_entry_req_i) begin
                    lp_state_d = flash_en ? LP_GRANT : LP_BLOCK; // see RULE_12
                end
            end
            LP_GRANT: begin
                if (!lp_entry_req_i) begin
                    lp_state_d = LP_IDLE;
                end else if (!flash_en) begin
                    lp_state_d = LP_BLOCK; // see RULE_12
                end
            end
            LP_BLOCK: begin
                if (!lp_entry_req_i) begin
                    lp_state_d = LP_IDLE;
                end
            end
            default: begin
                lp_state_d = LP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lp_state_q <= LP_IDLE;
        end else begin
            lp_state_q <= lp_state_d;
        end
    end

    assign lp_entry_grant_o = (lp_state_q == LP_GRANT);
    assign lp_entry_refused_o = (lp_state_q == LP_BLOCK);

    // status word, read only
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_FLASH_GATED_BIT] = ~flash_en;
        status_word[STAT_LP_BLOCKED_BIT] = (lp_state_q == LP_BLOCK);
        status_word[STAT_FLASH_READ_BIT] = flash_read_i;
        status_word[STAT_LP_GRANTED_BIT] = (lp_state_q == LP_GRANT);
    end

    // read mux; unmapped offsets read zero
    wire [31:0] view_a = group_view(gate_a_q, GATE_A_WMASK,
                                    GATE_A_ONES); // see RULE_13
    wire [31:0] view_b = group_view(gate_b_q, GATE_B_WMASK,
                                    GATE_B_ONES); // see RULE_13
    wire [31:0] view_c = group_view(gate_c_q, GATE_C_WMASK,
                                    GATE_C_ONES); // see RULE_14

    assign rdata_d = !reg_read_i ? 32'h0000_0000 :
                     sel_a ? view_a :
                     sel_b ? view_b :
                     sel_c ? view_c :
                     sel_stat ? status_word :
                     32'h0000_0000; // see RULE_14

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule

// ### testbench/clock_gating_sva.sv
// checker for the peripheral clock gating block
`timescale 1ns/1ps
module clock_gating_sva (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [31:0] reg_rdata_o,
    // gate levels and access
    input wire logic two_wire_port_gate_o,
    input wire logic lowpower_serial_gate_o,
    input wire logic second_gpio_gate_o,
    input wire logic first_gpio_gate_o,
    input wire logic converter_gate_o,
    input wire logic pwm_timer_one_gate_o,
    input wire logic pwm_timer_zero_gate_o,
    input wire logic flash_gate_o,
    input wire logic lowpower_timer_access_o,
    input wire logic rtc_access_o,
    // selects, interrupt, flash, low power
    input wire logic timer_sel_i,
    input wire logic timer_sel_o,
    input wire logic rtc_irq_i,
    input wire logic rtc_irq_o,
    input wire logic flash_read_i,
    input wire logic flash_read_clk_en_o,
    input wire logic lp_entry_req_i,
    input wire logic lp_entry_grant_o,
    input wire logic lp_entry_refused_o
);
    import clock_gating_pkg::*;
    wire [9:0] gv = {two_wire_port_gate_o, lowpower_serial_gate_o,
        second_gpio_gate_o, first_gpio_gate_o, converter_gate_o,
        pwm_timer_one_gate_o, pwm_timer_zero_gate_o, flash_gate_o,
        lowpower_timer_access_o, rtc_access_o};
    wire lp_idle = !lp_entry_grant_o && !lp_entry_refused_o;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 0)
        else $error("read data not zero outside read slot");
    group_a_write_a: assert property (
        reg_write_i && reg_addr_i == GATE_A_OFFSET |=>
        two_wire_port_gate_o == $past(reg_wdata_i[6]))
        else $error("group a gate not taken from write");
    group_b_write_a: assert property (
        reg_write_i && reg_addr_i == GATE_B_OFFSET |=> gv[8:6] ==
        $past({reg_wdata_i[20], reg_wdata_i[10], reg_wdata_i[9]}))
        else $error("group b gates not taken from write");
    group_c_write_a: assert property (
        reg_write_i && reg_addr_i == GATE_C_OFFSET |=> gv[5:2] ==
        $past({reg_wdata_i[27], reg_wdata_i[25:24], reg_wdata_i[0]}))
        else $error("group c gates not taken from write");
    gates_hold_a: assert property (!reg_write_i |=> $stable(gv))
        else $error("gate level changed without a write");
    timer_sel_a: assert property (
        timer_sel_o == (timer_sel_i & lowpower_timer_access_o))
        else $error("timer select not masked by access bit");
    rtc_irq_a: assert property (
        rtc_irq_o == $past(rtc_irq_i & rtc_access_o))
        else $error("rtc interrupt not masked by access bit");
    flash_read_a: assert property (
        flash_read_clk_en_o == (flash_read_i | flash_gate_o))
        else $error("flash clock enable wrong");
    lp_refuse_a: assert property (
        lp_entry_req_i && lp_idle && !flash_gate_o |=>
        lp_entry_refused_o && !lp_entry_grant_o)
        else $error("low-power entry not refused");
    lp_hold_a: assert property (
        lp_entry_req_i && lp_entry_refused_o |=> lp_entry_refused_o)
        else $error("refusal dropped while request held");
    lp_revoke_a: assert property (
        lp_entry_req_i && lp_entry_grant_o && !flash_gate_o |=>
        lp_entry_refused_o)
        else $error("grant not withdrawn when flash gated");
    cover property (lp_entry_refused_o);
    cover property (lp_entry_grant_o);
    cover property (flash_read_i && !flash_gate_o);
endmodule
bind peripheral_clock_gating clock_gating_sva clock_gating_sva_inst (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .two_wire_port_gate_o(two_wire_port_gate_o),
    .lowpower_serial_gate_o(lowpower_serial_gate_o),
    .second_gpio_gate_o(second_gpio_gate_o),
    .first_gpio_gate_o(first_gpio_gate_o),
    .converter_gate_o(converter_gate_o),
    .pwm_timer_one_gate_o(pwm_timer_one_gate_o),
    .pwm_timer_zero_gate_o(pwm_timer_zero_gate_o),
    .flash_gate_o(flash_gate_o),
    .lowpower_timer_access_o(lowpower_timer_access_o),
    .rtc_access_o(rtc_access_o), .timer_sel_i(timer_sel_i),
    .timer_sel_o(timer_sel_o), .rtc_irq_i(rtc_irq_i), .rtc_irq_o(rtc_irq_o),
    .flash_read_i(flash_read_i), .flash_read_clk_en_o(flash_read_clk_en_o),
    .lp_entry_req_i(lp_entry_req_i), .lp_entry_grant_o(lp_entry_grant_o),
    .lp_entry_refused_o(lp_entry_refused_o));

// ### testbench/tb.sv
// self-checking bench for the peripheral clock gating block
`timescale 1ns/1ps
module tb;
    import clock_gating_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [9:0] gates;
    } row_t;
    // gate order: two-wire, serial, gpio2, gpio1, conv, pwm1, pwm0, flash,
    // timer access, rtc access; rows build on each other
    row_t rows [8] = '{
        '{GATE_A_OFFSET, 32'hffff_ffff, 32'h0000_0070, 10'h204},
        '{GATE_B_OFFSET, 32'hffff_ffff, 32'h0010_0783, 10'h3c6},
        '{GATE_C_OFFSET, 32'hffff_ffff, 32'h2b00_0001, 10'h3ff},
        '{GATE_A_OFFSET, 32'h0000_0000, 32'h0000_0030, 10'h1ff},
        '{GATE_B_OFFSET, 32'h0000_0000, 32'h0000_0182, 10'h03d},
        '{GATE_C_OFFSET, 32'h0000_0000, 32'h0000_0000, 10'h000},
        '{8'h10, 32'hffff_ffff, 32'h0000_0000, 10'h000},
        '{GATE_C_OFFSET, 32'h0100_0000, 32'h0100_0000, 10'h008}};
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic timer_sel_i = 1'b0;
    logic rtc_sel_i = 1'b0;
    logic rtc_irq_i = 1'b0;
    logic flash_read_i = 1'b0;
    logic lp_entry_req_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic tw_g, sr_g, g2_g, g1_g, cv_g, p1_g, p0_g, fl_g;
    logic lt_acc, rt_acc, fl_en, lp_grant, lp_ref;
    logic lt_sel, rt_sel, rt_irq;
    logic [9:0] eg;
    // gated clocks in the same order as gates[9:2]
    wire [7:0] gclks;
    wire [9:0] gates = {tw_g, sr_g, g2_g, g1_g, cv_g, p1_g, p0_g, fl_g,
        lt_acc, rt_acc};
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    peripheral_clock_gating peripheral_clock_gating_inst (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .two_wire_port_gclk_o(gclks[7]),
        .lowpower_serial_gclk_o(gclks[6]), .second_gpio_gclk_o(gclks[5]),
        .first_gpio_gclk_o(gclks[4]), .converter_gclk_o(gclks[3]),
        .pwm_timer_one_gclk_o(gclks[2]), .pwm_timer_zero_gclk_o(gclks[1]),
        .flash_gclk_o(gclks[0]),
        .two_wire_port_gate_o(tw_g), .lowpower_serial_gate_o(sr_g),
        .second_gpio_gate_o(g2_g), .first_gpio_gate_o(g1_g),
        .converter_gate_o(cv_g), .pwm_timer_one_gate_o(p1_g),
        .pwm_timer_zero_gate_o(p0_g), .flash_gate_o(fl_g),
        .lowpower_timer_access_o(lt_acc), .timer_sel_i(timer_sel_i),
        .timer_sel_o(lt_sel), .rtc_access_o(rt_acc), .rtc_sel_i(rtc_sel_i),
        .rtc_sel_o(rt_sel), .rtc_irq_i(rtc_irq_i), .rtc_irq_o(rt_irq),
        .flash_read_i(flash_read_i), .flash_read_clk_en_o(fl_en),
        .lp_entry_req_i(lp_entry_req_i), .lp_entry_grant_o(lp_grant),
        .lp_entry_refused_o(lp_ref));
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic report_and_stop;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge core_clk_i);
        reg_write_i <= 1'b0;
    endtask
    // leaves the caller one ns after the edge that took the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge core_clk_i);
        reg_read_i <= 1'b0;
        #1;
        chk("rdata", exp, reg_rdata_o);
    endtask
    task automatic lp_step(input logic req, input logic [1:0] exp);
        @(posedge core_clk_i);
        lp_entry_req_i <= req;
        @(posedge core_clk_i);
        #1;
        chk("lp", {30'h0, exp}, {30'h0, lp_grant, lp_ref});
    endtask
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        timer_sel_i <= 1'b1;
        rtc_sel_i <= 1'b1;
        rtc_irq_i <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rdata);
            eg = rows[i].gates;
            chk("gate a", {31'h0, eg[9]}, {31'h0, gates[9]});
            chk("gate b", {29'h0, eg[8:6]},
                {29'h0, gates[8:6]});
            chk("timer", {31'h0, eg[1]}, {31'h0, gates[1]});
            chk("rtc", {31'h0, eg[0]}, {31'h0, gates[0]});
            chk("gate c", {28'h0, eg[5:2]},
                {28'h0, gates[5:2]});
            chk("gclk", {24'h0, eg[9:2]}, {24'h0, gclks});
            // selects held high, so outputs follow the access bits
            chk("sel", {29'h0, eg[1], eg[0], eg[0]},
                {29'h0, lt_sel, rt_sel, rt_irq});
        end
        // flash gate is now off: reads must still get a clock
        @(posedge core_clk_i);
        flash_read_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        chk("flash", 32'h3, {30'h0, fl_en, gclks[0]});
        @(posedge core_clk_i);
        flash_read_i <= 1'b0;
        lp_step(1'b1, 2'b01);
        wr(GATE_C_OFFSET, 32'h0000_0001);
        lp_step(1'b1, 2'b01);
        lp_step(1'b0, 2'b00);
        lp_step(1'b1, 2'b10);
        // gating flash while granted must withdraw the grant
        wr(GATE_C_OFFSET, 32'h0000_0000);
        lp_step(1'b1, 2'b01);
        lp_step(1'b0, 2'b00);
        // second reset in mid-run with gates changed
        wr(GATE_A_OFFSET, 32'hffff_ffff);
        arst_n_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        rd(GATE_A_OFFSET, 32'h0000_0030);
        rd(GATE_B_OFFSET, 32'h0000_0182);
        rd(GATE_C_OFFSET, 32'h0000_0001);
        chk("reset gates", 32'h004, {22'h0, gates});
        report_and_stop();
    end
endmodule
